// *** rtl/rad_addr_decoder.sv ***
// remote terminal address strap decoder top
// assumes straps are synchronous levels; this block compares cmd_addr against the adopted address
`timescale 1ns/1ps
module rad_addr_decoder
  import rad_pkg::*;
#(
  parameter int SETTLE_CYC = RAD_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strap pins, pulled up: an open line is one
  input wire logic [RAD_ADDR_W-1:0] strap_addr,
  input wire logic strap_parity,
  // select internal panel straps when not rack mounted
  input wire logic panel_mode,
  // address of an incoming command word
  input wire logic [RAD_ADDR_W-1:0] cmd_addr,
  input wire logic cmd_valid,
  // to the protocol logic
  output logic [RAD_ADDR_W-1:0] rt_addr,
  output logic addr_valid,
  output logic parity_err,
  output logic cmd_match
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rad_state_t st;
    rad_strap_t last;
    logic [RAD_CNT_W-1:0] cnt;
    logic [RAD_ADDR_W-1:0] addr;
    logic valid;
    logic perr;
    logic match;
  } rad_regs_t;

  rad_regs_t r_q;
  rad_regs_t r_d;
  rad_strap_t cur;
  logic odd_ok;

  // internal straps carry their own odd parity
  // line levels taken as read: ground is zero, open is one
  always_comb begin
    if (panel_mode) begin
      cur.addr = RAD_PANEL_ADDR;
      cur.parity = ~(^RAD_PANEL_ADDR);
    end else begin
      cur.addr = strap_addr;
      cur.parity = strap_parity;
    end
  end

  rad_parity_chk u_chk (
    .strap(cur),
    .odd_ok(odd_ok)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.last = cur;
    r_d.match = 1'b0;
    // a changing strap restarts the settle wait and withdraws the address
    if (cur != r_q.last) begin
      r_d.st = RAD_ST_SETTLE;
      r_d.cnt = '0;
      r_d.valid = 1'b0;
    end else begin
      unique case (r_q.st)
        RAD_ST_SETTLE: begin
          if (r_q.cnt >= RAD_CNT_W'(SETTLE_CYC - 1)) begin
            // adopt sampled address, bit zero lsb
            r_d.addr = cur.addr;
            r_d.valid = odd_ok;
            r_d.perr = ~odd_ok;
            r_d.st = odd_ok ? RAD_ST_VALID : RAD_ST_BAD;
          end else begin
            r_d.cnt = r_q.cnt + RAD_CNT_W'(1);
          end
        end
        RAD_ST_VALID: r_d.valid = 1'b1;
        RAD_ST_BAD: r_d.valid = 1'b0;
      endcase
    end
    // answer only own address; never when invalid
    if (cmd_valid && r_q.valid && (cmd_addr == r_q.addr) && (cur == r_q.last)) begin
      r_d.match = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_q.st <= RAD_ST_SETTLE;
      r_q.last <= '0;
      r_q.cnt <= '0;
      r_q.addr <= RAD_ADDR_RST;
      r_q.valid <= 1'b0;
      r_q.perr <= 1'b0;
      r_q.match <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign rt_addr = r_q.addr;
  assign addr_valid = r_q.valid;
  assign parity_err = r_q.perr;
  assign cmd_match = r_q.match;

endmodule : rad_addr_decoder

// *** rtl/rad_parity_chk.sv ***
// odd-parity checker over address and parity straps
// assumes the caller registers the result
`timescale 1ns/1ps
module rad_parity_chk
  import rad_pkg::*;
(
  // strap word
  input wire rad_strap_t strap,
  // result
  output logic odd_ok
);
  assign odd_ok = ^{strap.addr, strap.parity};
endmodule : rad_parity_chk

// *** rtl/rad_pkg.sv ***
// package for the remote terminal address strap decoder
// assumes straps arrive as plain synchronous levels, pull-ups already on board
package rad_pkg;

  // ----------------------------------------
  // widths and constants
  // ----------------------------------------
  localparam int RAD_ADDR_W = 5;
  localparam logic [RAD_ADDR_W-1:0] RAD_ADDR_RST = 5'h00;
  // straps must read the same for this many nanoseconds, rounded up to whole clock cycles, before they are believed
  localparam int RAD_SETTLE_NS = 1000;
  localparam int RAD_CLK_NS = 10;
  localparam int RAD_SETTLE_CYC = (RAD_SETTLE_NS + RAD_CLK_NS - 1) / RAD_CLK_NS;
  localparam int RAD_CNT_W = $clog2(RAD_SETTLE_CYC + 1);
  // internal strap value for a panel-mounted payload, fixed, not location dependent
  localparam logic [RAD_ADDR_W-1:0] RAD_PANEL_ADDR = 5'h05;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [RAD_ADDR_W-1:0] addr;
    logic parity;
  } rad_strap_t;

  typedef enum logic [1:0] {
    RAD_ST_SETTLE = 2'b00,
    RAD_ST_VALID = 2'b01,
    RAD_ST_BAD = 2'b11
  } rad_state_t;

endpackage : rad_pkg

// *** verif/rad_addr_decoder_tb_top.sv ***
// bench for the strap decoder
// assumes a short settle count of 4
`timescale 1ns/1ps
module rad_addr_decoder_tb_top;
  import rad_pkg::*;
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
  logic clk = 0, rst = 1, pm = 0, cv = 0, bad = 0, sp, av, pe, cm;
  logic [4:0] loc = 0, ca = 0, sa, rt;
  int err_total = 0, cmp_count = 0, seed = 32'h1521f3fb, r;
  always #5 clk = ~clk;
  rad_rack_wiring w (.loc(loc), .bad(bad), .sa(sa), .sp(sp));
  rad_addr_decoder #(.SETTLE_CYC(4)) uut (.clk(clk), .rst(rst), .strap_addr(sa), .strap_parity(sp),
    .panel_mode(pm), .cmd_addr(ca), .cmd_valid(cv), .rt_addr(rt), .addr_valid(av), .parity_err(pe), .cmd_match(cm));
  function automatic logic [4:0] ea(input logic [4:0] l, input logic p);
    return p ? RAD_PANEL_ADDR : l;
  endfunction : ea
  task automatic ask(input logic [4:0] a, input logic e);
    @(negedge clk);
    ca = a;
    cv = 1;
    @(negedge clk);
    cv = 0;
    `CHK("match", e, cm)
  endtask : ask
  task automatic put(input logic [4:0] l, input logic b, input logic p);
    @(negedge clk);
    loc = l;
    bad = b;
    pm = p;
    repeat (10) @(negedge clk);
    `CHK("valid", p | !b, av)
    `CHK("perr", !p & b, pe)
    if (p | !b) `CHK("addr", ea(l, p), rt)
    ask(ea(l, p), p | !b);
    ask(ea(l, p) ^ 5'h01, 1'b0);
  endtask : put
  task finish_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(negedge clk);
    `CHK("rst", 5'h00, rt)
    `CHK("rst_valid", 1'b0, av)
    rst = 0;
    put(5'h0f, 0, 0);
    put(5'h06, 0, 0);
    put(5'h00, 0, 0);
    put(5'h1f, 0, 0);
    put(5'h09, 1, 0);
    put(5'h03, 0, 1);
    repeat (20) begin
      r = $random(seed);
      put(r[4:0], r[5], r[6]);
    end
    finish_test;
  end
endmodule : rad_addr_decoder_tb_top

// *** verif/rad_asserts.sv ***
// checker on the strap decoder ports
// assumes one clock and a sync reset
`timescale 1ns/1ps
module rad_asserts import rad_pkg::*; #(parameter int SETTLE_CYC = 4) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // straps and commands
  input wire logic [RAD_ADDR_W-1:0] strap_addr,
  input wire logic strap_parity,
  input wire logic panel_mode,
  input wire logic [RAD_ADDR_W-1:0] cmd_addr,
  input wire logic cmd_valid,
  // results
  input wire logic [RAD_ADDR_W-1:0] rt_addr,
  input wire logic addr_valid,
  input wire logic parity_err,
  input wire logic cmd_match
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_HIT: assert property (cmd_valid && addr_valid && cmd_addr == rt_addr ##1 addr_valid |-> cmd_match)
    else $error("missed match");
  AST_NOHIT: assert property (cmd_match |-> $past(cmd_valid && addr_valid && cmd_addr == rt_addr))
    else $error("false match");
  AST_ERR: assert property (parity_err |-> !addr_valid)
    else $error("valid with error");
  AST_BIN: assert property ($rose(addr_valid) && !panel_mode |-> rt_addr == $past(strap_addr))
    else $error("wrong address");
  AST_ODD: assert property ($rose(addr_valid) && !panel_mode |-> $past(^{strap_addr, strap_parity}))
    else $error("even parity taken");
  AST_PANEL: assert property ($rose(addr_valid) && panel_mode |-> rt_addr == RAD_PANEL_ADDR)
    else $error("wrong panel address");
  AST_MOVE: assert property ($changed(strap_addr) && !panel_mode |-> ##[1:2] !addr_valid)
    else $error("moving straps kept");
endmodule : rad_asserts
bind rad_addr_decoder rad_asserts #(.SETTLE_CYC(SETTLE_CYC)) chk (
  .clk(clk),
  .rst(rst),
  .strap_addr(strap_addr),
  .strap_parity(strap_parity),
  .panel_mode(panel_mode),
  .cmd_addr(cmd_addr),
  .cmd_valid(cmd_valid),
  .rt_addr(rt_addr),
  .addr_valid(addr_valid),
  .parity_err(parity_err),
  .cmd_match(cmd_match)
);

// *** verif/rad_rack_wiring.sv ***
// rack wiring: location address with its parity strap
// assumes open lines read one through pull-ups
`timescale 1ns/1ps
module rad_rack_wiring (
  input wire logic [4:0] loc,
  input wire logic bad,
  output logic [4:0] sa,
  output logic sp
);
  // fixed odd strap set, bad flips parity
  assign sa = loc;
  assign sp = ~^loc ^ bad;
endmodule : rad_rack_wiring
